// >>> logic/usb_config_low_bits.sv
// Contract
// - burst limit applies only while enable bit set
// - pin exchange bit swaps positive and negative pads
// - pin exchange defaults eeprom, otp, else 0
// - remote wake advertised only when support set
// - remote wake defaults eeprom, otp, else 1
// - power select reports bus or self powered
// - power select eeprom only, else 1
// - loss of sync stalls bulk out unless disabled
// - loadable fields other than power select prefer eeprom, then otp, then default
// - usb or lite reset restores last image
// - l1 sleep defaults eeprom, otp, else 1
// - suspend allow defaults eeprom, otp, else 1
// - flags1 field defaults eeprom, otp, else 3h
// - flags2 fields default eeprom, otp, else 0
// - empty fifo in token: zlp or nak
`include "usb_cfg_params.svh"
`default_nettype none
module usb_config_low_bits
	import usb_cfg_pkg::*;
(
	// clock and reset
	input  wire logic                   clk_sys_i,
	input  wire logic                   rst_n_i,
	// configuration image sources
	input  wire logic                   load_strobe_i,
	input  wire logic                   eeprom_present_i,
	input  wire cfg_image_t             eeprom_image_i,
	input  wire logic                   otp_programmed_i,
	input  wire cfg_image_t             otp_image_i,
	// restore events
	input  wire logic                   usb_reset_i,
	input  wire logic                   lite_soft_reset_i,
	// software access
	input  wire logic                   sw_write_i,
	input  wire sw_bits_t               sw_wdata_i,
	output logic [`CFG_WORD_W-1:0]      cfg_word_o,
	output cfg_image_t                  cfg_fields_o,
	// transmit burst limiting
	input  wire logic [7:0]             burst_cap_i,
	output logic [7:0]                  tx_burst_limit_o,
	// pads and line
	input  wire logic                   usb2_positive_pad_i,
	input  wire logic                   usb2_negative_pad_i,
	output logic                        line_dplus_o,
	output logic                        line_dminus_o,
	// power and remote wake
	output logic                        self_powered_o,
	output logic                        remote_wake_adv_o,
	// bulk out stall on loss of sync
	input  wire logic                   loss_of_sync_i,
	input  wire logic                   stall_clear_i,
	output logic                        bulk_out_stall_o,
	// bulk in answer on empty fifo
	input  wire logic                   in_token_i,
	input  wire logic                   rx_fifo_empty_i,
	output logic                        in_resp_zlp_o,
	output logic                        in_resp_nak_o
);

	// pick one source for a loaded image, eeprom first, otp second
	function automatic cfg_image_t pick_image(
		input logic       ee_ok,
		input cfg_image_t ee,
		input logic       otp_ok,
		input cfg_image_t otp,
		input cfg_image_t dflt
	);
		cfg_image_t r;
		r = dflt;
		if (ee_ok) begin
			r = ee;
		end else if (otp_ok) begin
			r = otp;
		end
		// power method never comes from otp
		if (!ee_ok) begin
			r.power_source = dflt.power_source;
		end
		return r;
	endfunction : pick_image

	// fixed defaults when no source holds a value
	localparam cfg_image_t FIXED_DEFAULT = '{
		flags2_field:    `CFG_DEF_FLAGS2_FIELD,
		flags1_field:    `CFG_DEF_FLAGS1_FIELD,
		l1_sleep_enable: `CFG_DEF_L1_SLEEP,
		suspend_allow:   `CFG_DEF_SUSPEND,
		pin_exchange:    `CFG_DEF_PIN_EXCHANGE,
		remote_wake:     `CFG_DEF_REMOTE_WAKE,
		power_source:    `CFG_DEF_POWER_SRC
	};

	// image and live field state
	cfg_image_t image;           // last loaded image
	cfg_image_t next_image;
	cfg_image_t fields;          // live loadable fields
	cfg_image_t next_fields;
	logic       burst_en;        // burst limit enable
	logic       next_burst_en;
	logic       empty_resp;      // nak instead of zlp
	logic       next_empty_resp;
	logic       stall_dis;       // keep bulk out running
	logic       next_stall_dis;

	// image load and field restore; restore beats a same-cycle write to the loadable fields
	always_comb begin
		next_image      = image;
		next_fields     = fields;
		next_burst_en   = burst_en;
		next_empty_resp = empty_resp;
		next_stall_dis  = stall_dis;
		if (load_strobe_i) begin
			next_image = pick_image(eeprom_present_i, eeprom_image_i,
				otp_programmed_i, otp_image_i, FIXED_DEFAULT);
		end
		if (load_strobe_i) begin
			// a fresh load takes effect on the live fields at once
			next_fields = next_image;
		end else if (usb_reset_i || lite_soft_reset_i) begin
			next_fields = image;
		end else if (sw_write_i) begin
			// pin exchange is read only, so the write leaves it alone
			next_fields.remote_wake     = sw_wdata_i.remote_wake_support;
			next_fields.power_source    = sw_wdata_i.power_source_select;
			next_fields.l1_sleep_enable = sw_wdata_i.l1_sleep_enable;
			next_fields.suspend_allow   = sw_wdata_i.suspend_allow;
		end
		if (sw_write_i) begin
			next_burst_en   = sw_wdata_i.burst_limit_enable;
			next_empty_resp = sw_wdata_i.empty_in_response;
			next_stall_dis  = sw_wdata_i.bulk_out_stall_disable;
		end
	end

	// register the configuration state
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			image      <= FIXED_DEFAULT;
			fields     <= FIXED_DEFAULT;
			burst_en   <= `CFG_RST_BURST_EN;
			empty_resp <= `CFG_RST_EMPTY_IN_RESP;
			stall_dis  <= `CFG_RST_STALL_DIS;
		end else begin
			image      <= next_image;
			fields     <= next_fields;
			burst_en   <= next_burst_en;
			empty_resp <= next_empty_resp;
			stall_dis  <= next_stall_dis;
		end
	end

	// pad synchroniser; the pads are not on the core clock, so a change is
	// accepted only once the second and third stages agree, costing four cycles
	logic [1:0] pad_meta;       // first stage, read only by the second
	logic [1:0] pad_sync;       // second stage
	logic [1:0] pad_late;       // third stage
	logic [1:0] pad_level;      // accepted levels, {positive, negative}
	logic [1:0] next_pad_level;

	// take the new pad levels only when two stages match
	always_comb begin
		next_pad_level = pad_level;
		if (pad_sync == pad_late) begin
			next_pad_level = pad_late;
		end
	end

	// register the synchroniser stages
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pad_meta  <= 2'h0;
			pad_sync  <= 2'h0;
			pad_late  <= 2'h0;
			pad_level <= 2'h0;
		end else begin
			pad_meta  <= {usb2_positive_pad_i, usb2_negative_pad_i};
			pad_sync  <= pad_meta;
			pad_late  <= pad_sync;
			pad_level <= next_pad_level;
		end
	end

	// output side state
	logic [`CFG_WORD_W-1:0] next_cfg_word;
	logic [7:0]             next_burst_limit;
	logic                   next_dplus;
	logic                   next_dminus;
	logic                   next_stall;
	logic                   next_zlp;
	logic                   next_nak;

	// outputs follow the live state one cycle later, except cfg_word_o and cfg_fields_o, which track it
	always_comb begin
		next_cfg_word                         = '0; // reserved bits read zero
		next_cfg_word[`CFG_BIT_STALL_DIS]     = next_stall_dis;
		next_cfg_word[`CFG_BIT_POWER_SRC]     = next_fields.power_source;
		next_cfg_word[`CFG_BIT_REMOTE_WAKE]   = next_fields.remote_wake;
		next_cfg_word[`CFG_BIT_RESERVED3]     = 1'b0;
		next_cfg_word[`CFG_BIT_PIN_EXCHANGE]  = next_fields.pin_exchange;
		next_cfg_word[`CFG_BIT_BURST_EN]      = next_burst_en;
		next_cfg_word[`CFG_BIT_EMPTY_IN_RESP] = next_empty_resp;
		next_cfg_word[`CFG_BIT_L1_SLEEP]      = next_fields.l1_sleep_enable;
		// limit only when enabled, otherwise let bursts run full size
		if (burst_en) begin
			next_burst_limit = burst_cap_i;
		end else begin
			next_burst_limit = `CFG_BURST_UNLIMITED;
		end
		// pad mapping; swap bit exchanges the two pads
		if (fields.pin_exchange) begin
			next_dplus  = pad_level[0];
			next_dminus = pad_level[1];
		end else begin
			next_dplus  = pad_level[1];
			next_dminus = pad_level[0];
		end
		// stall is sticky; a loss of sync in the clear cycle still wins
		next_stall = bulk_out_stall_o;
		if (stall_clear_i) begin
			next_stall = 1'b0;
		end
		if (loss_of_sync_i && !stall_dis) begin
			next_stall = 1'b1;
		end
		// answer to an in token that meets an empty fifo
		next_zlp = in_token_i && rx_fifo_empty_i && !empty_resp;
		next_nak = in_token_i && rx_fifo_empty_i && empty_resp;
	end

	// register every output
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_word_o        <= '0;
			cfg_fields_o      <= FIXED_DEFAULT;
			tx_burst_limit_o  <= `CFG_BURST_UNLIMITED;
			line_dplus_o      <= 1'b0;
			line_dminus_o     <= 1'b0;
			self_powered_o    <= `CFG_DEF_POWER_SRC;
			remote_wake_adv_o <= 1'b0;
			bulk_out_stall_o  <= 1'b0;
			in_resp_zlp_o     <= 1'b0;
			in_resp_nak_o     <= 1'b0;
		end else begin
			cfg_word_o        <= next_cfg_word;
			cfg_fields_o      <= next_fields;
			tx_burst_limit_o  <= next_burst_limit;
			line_dplus_o      <= next_dplus;
			line_dminus_o     <= next_dminus;
			self_powered_o    <= fields.power_source;
			remote_wake_adv_o <= fields.remote_wake;
			bulk_out_stall_o  <= next_stall;
			in_resp_zlp_o     <= next_zlp;
			in_resp_nak_o     <= next_nak;
		end
	end

endmodule : usb_config_low_bits
`default_nettype wire

// >>> logic/usb_cfg_params.svh
`ifndef USB_CFG_PARAMS_SVH
`define USB_CFG_PARAMS_SVH
// bit positions in the low configuration word
`define CFG_BIT_STALL_DIS     0
`define CFG_BIT_POWER_SRC     1
`define CFG_BIT_REMOTE_WAKE   2
`define CFG_BIT_RESERVED3     3
`define CFG_BIT_PIN_EXCHANGE  4
`define CFG_BIT_BURST_EN      5
`define CFG_BIT_EMPTY_IN_RESP 6
`define CFG_BIT_RESERVED7     7
`define CFG_BIT_L1_SLEEP      8
`define CFG_WORD_W            9
// reset values of plain software bits
`define CFG_RST_STALL_DIS     1'b0
`define CFG_RST_BURST_EN      1'b0
`define CFG_RST_EMPTY_IN_RESP 1'b0
// fixed defaults of loadable fields
`define CFG_DEF_PIN_EXCHANGE  1'b0
`define CFG_DEF_REMOTE_WAKE   1'b1
`define CFG_DEF_POWER_SRC     1'b1
`define CFG_DEF_L1_SLEEP      1'b1
`define CFG_DEF_SUSPEND       1'b1
`define CFG_DEF_FLAGS1_FIELD  2'h3
`define CFG_DEF_FLAGS2_FIELD  8'h00
// burst limit when limiting is off
`define CFG_BURST_UNLIMITED   8'hff
`endif

// >>> logic/usb_cfg_pkg.sv
`default_nettype none
package usb_cfg_pkg;
	// one image of every loadable configuration field
	typedef struct packed {
		logic [7:0] flags2_field;    // flags word 2 field
		logic [1:0] flags1_field;    // flags word 1 field
		logic       l1_sleep_enable; // flags word 1 bit
		logic       suspend_allow;   // flags word 0 suspend enable
		logic       pin_exchange;    // flags word 0 pin swap
		logic       remote_wake;     // flags word 0 remote wake
		logic       power_source;    // flags word 0 power method
	} cfg_image_t;
	// software side write data for the low bits
	typedef struct packed {
		logic burst_limit_enable;
		logic empty_in_response;
		logic remote_wake_support;
		logic power_source_select;
		logic bulk_out_stall_disable;
		logic l1_sleep_enable;
		logic suspend_allow;
	} sw_bits_t;
endpackage : usb_cfg_pkg
`default_nettype wire

// >>> tb/usb_config_low_bits_monitor.sv
`include "usb_cfg_params.svh"
`default_nettype none
module usb_config_low_bits_monitor
	import usb_cfg_pkg::*;
(
	// clock, reset, config events
	input wire logic                  clk_sys_i,
	input wire logic                  rst_n_i,
	input wire logic                  load_strobe_i,
	input wire logic                  usb_reset_i,
	input wire logic                  lite_soft_reset_i,
	input wire logic                  sw_write_i,
	input wire sw_bits_t              sw_wdata_i,
	input wire logic [`CFG_WORD_W-1:0] cfg_word_o,
	// effects
	input wire logic [7:0]            burst_cap_i,
	input wire logic [7:0]            tx_burst_limit_o,
	input wire logic                  self_powered_o,
	input wire logic                  remote_wake_adv_o,
	input wire logic                  loss_of_sync_i,
	input wire logic                  stall_clear_i,
	input wire logic                  bulk_out_stall_o,
	input wire logic                  in_token_i,
	input wire logic                  rx_fifo_empty_i,
	input wire logic                  in_resp_zlp_o,
	input wire logic                  in_resp_nak_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// load and restore outrank a write to the loadable fields, so only a lone write counts
	wire logic restore = usb_reset_i | lite_soft_reset_i;
	wire logic quiet   = !sw_write_i && !load_strobe_i && !restore;
	wire logic wr_only = sw_write_i && !load_strobe_i && !restore;
	// a quiet cycle after the write lets the two-cycle outputs settle
	sequence s_write;
		wr_only ##1 quiet;
	endsequence
	property p_burst;
		s_write |=> tx_burst_limit_o ==
			($past(sw_wdata_i.burst_limit_enable, 2) ? $past(burst_cap_i) : 8'hff);
	endproperty
	a_burst: assert property (p_burst) else $error("burst limit wrong");
	property p_wake;
		s_write |=> remote_wake_adv_o == $past(sw_wdata_i.remote_wake_support, 2);
	endproperty
	a_wake: assert property (p_wake) else $error("wake advert wrong");
	property p_power;
		s_write |=> self_powered_o == $past(sw_wdata_i.power_source_select, 2);
	endproperty
	a_power: assert property (p_power) else $error("power mode wrong");
	property p_fixed_bits;
		wr_only |=> $stable(cfg_word_o[4]) && !cfg_word_o[3] && !cfg_word_o[7];
	endproperty
	a_fixed_bits: assert property (p_fixed_bits) else $error("fixed bit moved");
	property p_stall_set;
		loss_of_sync_i && !cfg_word_o[0] |=> bulk_out_stall_o;
	endproperty
	a_stall_set: assert property (p_stall_set) else $error("no stall");
	property p_stall_hold;
		bulk_out_stall_o && !stall_clear_i |=> bulk_out_stall_o;
	endproperty
	a_stall_hold: assert property (p_stall_hold) else $error("stall dropped");
	// a stall may only come from an enabled loss of sync
	property p_stall_cause;
		!bulk_out_stall_o && !(loss_of_sync_i && !cfg_word_o[0]) |=> !bulk_out_stall_o;
	endproperty
	a_stall_cause: assert property (p_stall_cause) else $error("stray stall");
	property p_in_answer;
		in_token_i && rx_fifo_empty_i |=>
			in_resp_nak_o == $past(cfg_word_o[6]) && in_resp_zlp_o == !$past(cfg_word_o[6]);
	endproperty
	a_in_answer: assert property (p_in_answer) else $error("empty answer wrong");
	property p_in_quiet;
		!(in_token_i && rx_fifo_empty_i) |=> !in_resp_zlp_o && !in_resp_nak_o;
	endproperty
	a_in_quiet: assert property (p_in_quiet) else $error("stray answer");
	c_stall: cover property (loss_of_sync_i && !cfg_word_o[0]);
	c_nak: cover property (in_token_i && rx_fifo_empty_i && cfg_word_o[6]);
	c_restore: cover property (restore && !load_strobe_i);
endmodule : usb_config_low_bits_monitor
bind usb_config_low_bits usb_config_low_bits_monitor usb_config_low_bits_monitor_inst (
	.clk_sys_i, .rst_n_i, .load_strobe_i, .usb_reset_i, .lite_soft_reset_i, .sw_write_i,
	.sw_wdata_i, .cfg_word_o, .burst_cap_i, .tx_burst_limit_o, .self_powered_o,
	.remote_wake_adv_o, .loss_of_sync_i, .stall_clear_i, .bulk_out_stall_o, .in_token_i,
	.rx_fifo_empty_i, .in_resp_zlp_o, .in_resp_nak_o);
`default_nettype wire

// >>> tb/usb_config_low_bits_test.sv
`default_nettype none
module usb_config_low_bits_test
	import usb_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk_sys_i, rst_n_i, load_strobe_i, eeprom_present_i, otp_programmed_i;
	logic       usb_reset_i, lite_soft_reset_i, sw_write_i, loss_of_sync_i, stall_clear_i;
	logic       usb2_positive_pad_i, usb2_negative_pad_i, in_token_i, rx_fifo_empty_i;
	logic       line_dplus_o, line_dminus_o, self_powered_o, remote_wake_adv_o;
	logic       bulk_out_stall_o, in_resp_zlp_o, in_resp_nak_o;
	logic [8:0] cfg_word_o;
	logic [7:0] burst_cap_i, tx_burst_limit_o;
	cfg_image_t eeprom_image_i, otp_image_i, cfg_fields_o;
	sw_bits_t   sw_wdata_i;
	int         error_cnt, n_checks, cyc;
	usb_config_low_bits usb_config_low_bits_inst (.clk_sys_i, .rst_n_i, .load_strobe_i,
		.eeprom_present_i, .eeprom_image_i, .otp_programmed_i, .otp_image_i, .usb_reset_i,
		.lite_soft_reset_i, .sw_write_i, .sw_wdata_i, .cfg_word_o, .cfg_fields_o,
		.burst_cap_i, .tx_burst_limit_o, .usb2_positive_pad_i, .usb2_negative_pad_i,
		.line_dplus_o, .line_dminus_o, .self_powered_o, .remote_wake_adv_o,
		.loss_of_sync_i, .stall_clear_i, .bulk_out_stall_o, .in_token_i,
		.rx_fifo_empty_i, .in_resp_zlp_o, .in_resp_nak_o);
	// 250 MHz clock and a hang guard well past the 116 cycles needed
	initial begin
		clk_sys_i = 0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc > 3000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	// inputs move 1 ns after the edge
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : step
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask : chk
	// one-cycle pulse, then three quiet cycles for the slow outputs
	task automatic pulse(ref logic s);
		s = 1;
		step(1);
		s = 0;
		step(3);
	endtask : pulse
	task automatic wr(input sw_bits_t v);
		sw_wdata_i = v;
		pulse(sw_write_i);
	endtask : wr
	task automatic ld(input logic e, input logic o);
		eeprom_present_i = e;
		otp_programmed_i = o;
		pulse(load_strobe_i);
	endtask : ld
	task automatic t_load;
		ld(0, 1);
		chk(cfg_fields_o === 15'h1e45, "otp image");
		ld(1, 1);
		chk(cfg_fields_o === 15'h52a4, "eeprom image");
		chk({line_dplus_o, line_dminus_o} === 2'b01, "pads");
		chk({self_powered_o, remote_wake_adv_o} === 2'b00, "power wake");
		wr(7'h7f);
		chk(cfg_word_o === 9'h177, "word");
		pulse(usb_reset_i);
		chk({cfg_fields_o, cfg_word_o} === {15'h52a4, 9'h071}, "usb restore");
		wr(7'h7f);
		pulse(lite_soft_reset_i);
		chk({cfg_fields_o, cfg_word_o} === {15'h52a4, 9'h071}, "lite restore");
		ld(0, 0);
		chk(cfg_fields_o === 15'h007b, "defaults");
		chk({line_dplus_o, line_dminus_o} === 2'b10, "pads straight");
	endtask : t_load
	task automatic t_write;
		burst_cap_i = 8'h20;
		wr(7'h40);
		chk(tx_burst_limit_o === 8'h20, "capped");
		wr(7'h08);
		chk({tx_burst_limit_o, self_powered_o, remote_wake_adv_o} === 10'h3fe, "pw");
		wr(7'h10);
		chk({self_powered_o, remote_wake_adv_o} === 2'b01, "wake");
	endtask : t_write
	task automatic t_stall;
		wr(7'h00);
		pulse(loss_of_sync_i);
		chk(bulk_out_stall_o === 1'b1, "sticky stall");
		pulse(stall_clear_i);
		chk(bulk_out_stall_o === 1'b0, "cleared");
		wr(7'h04);
		pulse(loss_of_sync_i);
		chk(bulk_out_stall_o === 1'b0, "disabled");
	endtask : t_stall
	task automatic t_in;
		for (int r = 0; r < 2; r++) begin
			wr(r ? 7'h20 : 7'h00);
			rx_fifo_empty_i = 1;
			in_token_i = 1;
			step(1);
			chk({in_resp_zlp_o, in_resp_nak_o} === (r ? 2'b01 : 2'b10), "answer");
			in_token_i = 0;
			step(1);
			chk({in_resp_zlp_o, in_resp_nak_o} === 2'b00, "one pulse");
		end
	endtask : t_in
	// hold reset 20 cycles, release off the edge, then check the reset image
	task automatic t_reset;
		rst_n_i = 0;
		step(20);
		rst_n_i = 1;
		step(2);
		chk({cfg_word_o, cfg_fields_o} === {9'h106, 15'h007b}, "reset");
		chk({tx_burst_limit_o, self_powered_o} === 9'h1ff, "reset out");
		chk(bulk_out_stall_o === 1'b0, "reset stall");
	endtask : t_reset
	task automatic tally_and_finish;
		if (error_cnt == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		{rst_n_i, load_strobe_i, eeprom_present_i, otp_programmed_i, usb_reset_i} = '0;
		{lite_soft_reset_i, sw_write_i, loss_of_sync_i, stall_clear_i, in_token_i} = '0;
		{usb2_positive_pad_i, usb2_negative_pad_i, rx_fifo_empty_i, burst_cap_i} = 11'h400;
		eeprom_image_i = 15'h52a4;
		otp_image_i = 15'h1e44;
		sw_wdata_i = '0;
		t_reset();
		t_load();
		t_write();
		t_stall();
		t_in();
		t_reset();
		tally_and_finish();
	end
endmodule : usb_config_low_bits_test
`default_nettype wire
